// file: eewp_port.v
// Purpose: Slave side of a two-wire memory write port.
// Assumes: Bus clock and data arrive from pins, outside CLK's domain.
// Notes:   Words accepted without write protect leave on a buffered stream; reads are elsewhere.
`include "eewp_defines.vh"

module eewp_port #(
    parameter [`EEWP_WR_CNT_W-1:0] WRITE_CYCLES = `EEWP_WR_CYCLES
) (
    // Clock and reset
    input  wire                     CLK,
    input  wire                     RESET_N,
    // Two-wire link
    input  wire                     SCL_IN,
    input  wire                     SDA_IN,
    output reg                      SDA_OUT,
    output reg                      SDA_OE,
    // Straps and protection
    input  wire                     SELECT_STRAP_HIGH,
    input  wire                     SELECT_STRAP_MID,
    input  wire                     SELECT_STRAP_LOW,
    input  wire                     WRITE_PROTECT,
    // Word stream to the array
    output wire                     WORD_VALID,
    output wire [`EEWP_ADDR_W-1:0]  WORD_ADDR,
    output wire [`EEWP_DATA_W-1:0]  WORD_DATA,
    input  wire                     WORD_READY,
    // Status
    output reg                      WRITE_COMMIT,
    output reg                      WRITE_BUSY,
    output reg                      STANDBY
);

    // Protocol states
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_DEV  = 7'h02;
    localparam [6:0] ST_HI   = 7'h04;
    localparam [6:0] ST_LO   = 7'h08;
    localparam [6:0] ST_DATA = 7'h10;
    localparam [6:0] ST_ACK  = 7'h20;
    localparam [6:0] ST_SKIP = 7'h40;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Reset to bus idle, so lines already high at release give no false start.
    // The third flops of clock and data feed only the edge detectors.
    // Straps and protect are static levels and need no edge history.
    reg        scl_m_q;
    reg        scl_s_q;
    reg        scl_p_q;
    reg        sda_m_q;
    reg        sda_s_q;
    reg        sda_p_q;
    reg  [3:0] pin_m_q;
    reg  [3:0] pin_s_q;

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            pin_m_q <= 4'h0;
            pin_s_q <= 4'h0;
        end else begin
            scl_m_q <= SCL_IN;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= SDA_IN;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            pin_m_q <= {WRITE_PROTECT, SELECT_STRAP_HIGH, SELECT_STRAP_MID,
                        SELECT_STRAP_LOW};
            pin_s_q <= pin_m_q;
        end
    end

    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;
    wire [2:0] strap;
    wire       wp;

    assign scl_rise  = scl_s_q & ~scl_p_q;
    assign scl_fall  = ~scl_s_q & scl_p_q;
    assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_det  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign strap     = pin_s_q[2:0];
    assign wp        = pin_s_q[3];

    ////////////////////////////////////////////////////////////////////////////
    // Word buffer

    // Two words absorb a short sink stall; a third byte is refused on the
    // bus, because nothing here can hold it.
    reg                      push_q;
    reg  [`EEWP_WORD_W-1:0]  push_word_q;
    wire                     buf_ready;
    wire [`EEWP_WORD_W-1:0]  buf_word;

    eewp_buf2 #(
        .WIDTH     (`EEWP_WORD_W)
    ) u_buf (
        .clk       (CLK),
        .reset_n   (RESET_N),
        .in_valid  (push_q),
        .in_data   (push_word_q),
        .in_ready  (buf_ready),
        .out_valid (WORD_VALID),
        .out_data  (buf_word),
        .out_ready (WORD_READY)
    );

    assign WORD_ADDR = buf_word[`EEWP_WORD_W-1:`EEWP_DATA_W];
    assign WORD_DATA = buf_word[`EEWP_DATA_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Byte engine

    reg  [6:0]                state_q;
    reg  [6:0]                after_ack_q;
    reg  [2:0]                bit_cnt_q;
    reg  [7:0]                shift_q;
    reg                       ack_on_q;
    reg                       rw_q;
    reg                       wr_seen_q;
    reg  [`EEWP_ADDR_W-1:0]   addr_q;
    reg  [`EEWP_WR_CNT_W-1:0] wr_cnt_q;

    wire [7:0] byte_in;
    wire       last_bit;
    wire       dev_match;
    wire       in_write;
    wire [6:0] page_next;
    wire       family_ok;
    wire       select_ok;
    wire       commit_now;

    assign byte_in  = {shift_q[6:0], sda_s_q};
    assign last_bit = (bit_cnt_q == `EEWP_LAST_BIT);

    assign family_ok = (byte_in[`EEWP_FAMILY_MSB:`EEWP_FAMILY_LSB] == `EEWP_FAMILY_CODE);
    assign select_ok = (byte_in[`EEWP_SELECT_MSB:`EEWP_SELECT_LSB] == strap);
    // busy refuses all
    // Polling depends on this: the refused word is the busy answer
    assign dev_match = family_ok & select_ok & ~WRITE_BUSY;
    assign in_write  = ~rw_q & wr_seen_q;
    assign page_next = addr_q[`EEWP_PAGE_BITS-1:0] + 7'h01;
    // protected write dropped
    // A stop after address bytes only leaves the array alone
    assign commit_now = stop_det & in_write & ~wp & ~WRITE_BUSY;

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_q      <= ST_IDLE;
            after_ack_q  <= ST_IDLE;
            bit_cnt_q    <= 3'h0;
            shift_q      <= 8'h00;
            ack_on_q     <= 1'b0;
            rw_q         <= 1'b0;
            wr_seen_q    <= 1'b0;
            addr_q       <= 16'h0000;
            push_q       <= 1'b0;
            push_word_q  <= 24'h000000;
            SDA_OE       <= 1'b0;
        end else begin
            push_q       <= 1'b0;

            if (start_det) begin
                state_q   <= ST_DEV;
                bit_cnt_q <= 3'h0;
                ack_on_q  <= 1'b0;
                wr_seen_q <= 1'b0;
                SDA_OE    <= 1'b0;
            end else if (stop_det) begin
                // The cycle timer takes the commit from this same stop
                state_q   <= ST_IDLE;
                wr_seen_q <= 1'b0;
                ack_on_q  <= 1'b0;
                SDA_OE    <= 1'b0;
            end else begin
                case (state_q)
                    ST_DEV, ST_HI, ST_LO, ST_DATA: begin
                        if (scl_rise) begin
                            shift_q   <= byte_in;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (last_bit) begin
                                state_q <= ST_ACK;
                                case (state_q)
                                    ST_DEV: begin
                                        if (dev_match) begin
                                            rw_q        <= byte_in[`EEWP_RW_BIT];
                                            after_ack_q <= byte_in[`EEWP_RW_BIT] ?
                                                           ST_SKIP : ST_HI;
                                        end else begin
                                            state_q <= ST_SKIP;
                                        end
                                    end
                                    ST_HI: begin
                                        addr_q[15:8] <= byte_in;
                                        after_ack_q  <= ST_LO;
                                    end
                                    ST_LO: begin
                                        addr_q[7:0] <= byte_in;
                                        after_ack_q <= ST_DATA;
                                    end
                                    default: begin
                                        after_ack_q <= ST_DATA;
                                        if (!buf_ready) begin
                                            // Full buffer: refuse rather than lose
                                            state_q <= ST_SKIP;
                                        end else begin
                                            push_q      <= ~wp;
                                            push_word_q <= {addr_q, byte_in};
                                            wr_seen_q   <= 1'b1;
                                            addr_q[`EEWP_PAGE_BITS-1:0] <= page_next;
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                    ST_ACK: begin
                        // ninth-clock acknowledge
                        // First fall ends the eighth bit and pulls the line,
                        // the second ends the ninth and lets it go.
                        if (scl_fall) begin
                            if (!ack_on_q) begin
                                ack_on_q <= 1'b1;
                                SDA_OE   <= 1'b1;
                            end else begin
                                ack_on_q  <= 1'b0;
                                SDA_OE    <= 1'b0;
                                bit_cnt_q <= 3'h0;
                                state_q   <= after_ack_q;
                            end
                        end
                    end
                    ST_SKIP: begin
                        // Wait for next start or stop
                        // Read data is served elsewhere, so the line stays free
                        SDA_OE <= 1'b0;
                    end
                    ST_IDLE: begin
                        SDA_OE <= 1'b0;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        SDA_OE  <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-timed write cycle and status

    // Kept apart from the byte engine, so a start during the cycle
    // resyncs the engine without touching the timer.
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_cnt_q     <= {`EEWP_WR_CNT_W{1'b0}};
            WRITE_COMMIT <= 1'b0;
            WRITE_BUSY   <= 1'b0;
            STANDBY      <= 1'b1;
        end else begin
            WRITE_COMMIT <= commit_now;
            if (commit_now) begin
                WRITE_BUSY <= 1'b1;
                wr_cnt_q   <= {`EEWP_WR_CNT_W{1'b0}};
            end else if (WRITE_BUSY) begin
                if (wr_cnt_q == WRITE_CYCLES - 1'b1) begin
                    WRITE_BUSY <= 1'b0;
                    wr_cnt_q   <= {`EEWP_WR_CNT_W{1'b0}};
                end else begin
                    wr_cnt_q <= wr_cnt_q + 1'b1;
                end
            end
            STANDBY <= (state_q == ST_IDLE) & ~WRITE_BUSY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data line drive

    // only ever pull low
    // Drive value stays zero; SDA_OE alone decides whether the pin is pulled
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SDA_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
        end
    end

endmodule // eewp_port

// file: eewp_defines.vh
// Purpose: Constants for the two-wire memory write port.
// Assumes: Core clock of 125 MHz.
// Notes:   Timing counts derive from the printed times.
`ifndef EEWP_DEFINES_VH
`define EEWP_DEFINES_VH

// Device address word layout
`define EEWP_FAMILY_CODE    4'ha
`define EEWP_FAMILY_MSB     7
`define EEWP_FAMILY_LSB     4
`define EEWP_SELECT_MSB     3
`define EEWP_SELECT_LSB     1
`define EEWP_RW_BIT         0

// Byte framing
`define EEWP_LAST_BIT       3'h7
`define EEWP_PAGE_BITS      7

// Word stream layout
`define EEWP_ADDR_W         16
`define EEWP_DATA_W         8
`define EEWP_WORD_W         24

// Self-timed write cycle
`define EEWP_CLK_MHZ        125
`define EEWP_WR_TIME_MS     5
`define EEWP_WR_CYCLES      (`EEWP_WR_TIME_MS * 1000 * `EEWP_CLK_MHZ)
`define EEWP_WR_CNT_W       20

`endif

// file: eewp_buf2.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Outputs and in_ready come straight from flip-flops.
module eewp_buf2 #(
    parameter WIDTH = 24
) (
    // Clock and reset
    input  wire             clk,
    input  wire             reset_n,
    // Filling side
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output reg              in_ready,
    // Draining side
    output reg              out_valid,
    output reg  [WIDTH-1:0] out_data,
    input  wire             out_ready
);

    reg [WIDTH-1:0] tail_q;
    reg             tail_v_q;
    wire            push;
    wire            pop;

    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
            tail_q    <= {WIDTH{1'b0}};
            tail_v_q  <= 1'b0;
            in_ready  <= 1'b1;
        end else begin
            if (pop) begin
                if (tail_v_q) begin
                    out_data <= tail_q;
                    tail_v_q <= push;
                    in_ready <= ~push;
                    if (push) begin
                        tail_q <= in_data;
                    end
                end else begin
                    out_valid <= push;
                    if (push) begin
                        out_data <= in_data;
                    end
                end
            end else if (push) begin
                if (!out_valid) begin
                    out_valid <= 1'b1;
                    out_data  <= in_data;
                end else begin
                    tail_q   <= in_data;
                    tail_v_q <= 1'b1;
                    // Full: refuse until the drain side takes a word
                    in_ready <= 1'b0;
                end
            end
        end
    end

endmodule // eewp_buf2

// file: eewp_port_assertions.sv
// Purpose: Concurrent checks on the pins of the write port.
// Assumes: Bound to eewp_port; one clock domain.
// Notes:   Busy length is counted in helper logic.
`include "eewp_defines.vh"
module eewp_port_chk #(
    parameter [`EEWP_WR_CNT_W-1:0] WRITE_CYCLES = `EEWP_WR_CYCLES
) (
    // Clock and reset
    input wire                    CLK,
    input wire                    RESET_N,
    // Two-wire link
    input wire                    SCL_IN,
    input wire                    SDA_IN,
    input wire                    SDA_OUT,
    input wire                    SDA_OE,
    // Protection
    input wire                    WRITE_PROTECT,
    // Word stream
    input wire                    WORD_VALID,
    input wire [`EEWP_ADDR_W-1:0] WORD_ADDR,
    input wire [`EEWP_DATA_W-1:0] WORD_DATA,
    input wire                    WORD_READY,
    // Status
    input wire                    WRITE_COMMIT,
    input wire                    WRITE_BUSY,
    input wire                    STANDBY
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////////////////////////////////////////////
    reg  [`EEWP_WR_CNT_W-1:0] busy_cnt_q;
    wire [`EEWP_WR_CNT_W-1:0] busy_cnt_d = WRITE_BUSY ? busy_cnt_q + 1'b1 : '0;
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
            busy_cnt_q <= '0;
        else
            busy_cnt_q <= busy_cnt_d;
    end
    sequence s_ack_slot;
        SDA_OE [*8] ##[1:16] !SDA_OE;
    endsequence
    sequence s_commit_tail;
        !WRITE_COMMIT && WRITE_BUSY && !STANDBY;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_drive_low_only: assert property (SDA_OE |-> !SDA_OUT)
        else $error("data line driven high");
    a_ack_clock_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
        else $error("acknowledge moved while bus clock high");
    a_ack_one_slot: assert property ($rose(SDA_OE) |-> s_ack_slot)
        else $error("acknowledge not held for one bit slot");
    a_no_ack_busy: assert property ($rose(SDA_OE) |-> !WRITE_BUSY)
        else $error("acknowledge during write cycle");
    a_commit_pulse: assert property (WRITE_COMMIT |=> s_commit_tail)
        else $error("commit not a single pulse into busy");
    a_commit_after_stop: assert property (WRITE_COMMIT |-> SCL_IN && SDA_IN)
        else $error("commit without bus stop");
    a_busy_length: assert property ($fell(WRITE_BUSY) |-> busy_cnt_q == WRITE_CYCLES)
        else $error("write cycle length wrong");
    a_standby_idle: assert property (STANDBY |-> !WRITE_BUSY && !SDA_OE)
        else $error("standby while active");
    a_protect_no_commit: assert property (WRITE_PROTECT |-> !WRITE_COMMIT)
        else $error("commit while protected");
    a_protect_no_word: assert property (WRITE_PROTECT && !WORD_VALID |=> !WORD_VALID)
        else $error("word streamed while protected");
    a_stream_hold: assert property (WORD_VALID && !WORD_READY |=>
        WORD_VALID && $stable({WORD_ADDR, WORD_DATA}))
        else $error("stalled word changed");
endmodule // eewp_port_chk

// file: eewp_master.sv
// Purpose: Behavioural two-wire bus master for the write port.
// Assumes: Bus clock period 125 ns; data line pulled up outside.
// Notes:   Bus clock stands high between frames.
module eewp_master (
    // Bus lines
    output logic scl,
    output logic sda_low,
    input  wire  sda
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam real QTR = 31.25;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic bit_out(input logic b);
        #QTR sda_low = !b;
        #QTR scl = 1'b1;
        #(2 * QTR) scl = 1'b0;
    endtask
    task automatic start_cond();
        #QTR sda_low = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b1;
        #QTR scl = 1'b0;
    endtask
    task automatic stop_cond();
        #QTR sda_low = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_low = 1'b0;
        #QTR;
    endtask
    task automatic write_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_out(b[i]);
        #QTR sda_low = 1'b0;
        #QTR scl = 1'b1;
        #QTR ack = (sda === 1'b0);
        #QTR scl = 1'b0;
    endtask
endmodule // eewp_master

// file: test_two_wire_eeprom_write_port.sv
// Purpose: Self-checking bench of the write port against a bus master.
// Assumes: Short write cycle of 400 clocks.
// Notes:   Sink stalls only in the buffer test.
module test_two_wire_eeprom_write_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] CYC = 20'd400;
    logic        clk, reset_n, wp, word_ready, a;
    logic [2:0]  strap;
    logic [6:0]  lo;
    wire         scl, m_low, sda_oe, sda_out, word_valid, commit, busy, standby;
    wire  [15:0] word_addr;
    wire  [7:0]  word_data;
    int          fail_count, checks, commits, n;
    logic [23:0] wq[$];
    logic [7:0]  adr[4] = '{8'hab, 8'hba, 8'ha8, 8'h2a};
    // Open-drain wire with pull-up
    wire sda = (m_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    eewp_master m (.scl(scl), .sda_low(m_low), .sda(sda));
    eewp_port #(.WRITE_CYCLES(CYC)) uut (
        .CLK(clk), .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SELECT_STRAP_HIGH(strap[2]),
        .SELECT_STRAP_MID(strap[1]), .SELECT_STRAP_LOW(strap[0]), .WRITE_PROTECT(wp),
        .WORD_VALID(word_valid), .WORD_ADDR(word_addr), .WORD_DATA(word_data),
        .WORD_READY(word_ready), .WRITE_COMMIT(commit), .WRITE_BUSY(busy),
        .STANDBY(standby));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (word_valid && word_ready)
            wq.push_back({word_addr, word_data});
        if (commit)
            commits++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpw(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pop_word(input logic [23:0] exp);
        cmpw(wq.size() > 0 ? wq.pop_front() : 24'hxxxxxx, exp);
    endtask
    task automatic send(input logic [7:0] b, input logic exp);
        logic k;
        m.write_byte(b, k);
        cmp1(k, exp);
    endtask
    task automatic wait_idle();
        int w;
        w = 0;
        while (standby !== 1'b1 && w < 2000) begin
            @(posedge clk);
            #1;
            w++;
        end
        cmp1(standby, 1'b1);
    endtask
    task automatic done(input string name);
        $display("test %s done, checks=%0d", name, checks);
    endtask
    task automatic summarize();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #250000;
        fail_count++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        wp = 1'b0;
        word_ready = 1'b1;
        strap = 3'b101;
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk);
        cmp1(standby, 1'b1);
        m.start_cond();
        send(8'haa, 1'b1);
        send(8'h12, 1'b1);
        send(8'h34, 1'b1);
        send(8'h5a, 1'b1);
        m.stop_cond();
        n = 0;
        a = 1'b0;
        while (!a && n < 8) begin
            m.start_cond();
            m.write_byte(8'haa, a);
            n++;
        end
        m.stop_cond();
        cmp1(a && n > 1, 1'b1);
        cmp1(busy, 1'b0);
        cmp1(commits == 1, 1'b1);
        pop_word(24'h12345a);
        wait_idle();
        done("byte write and polling");
        for (int i = 0; i < 4; i++) begin
            m.start_cond();
            send(adr[i], i == 0);
            m.stop_cond();
            wait_idle();
        end
        done("address decode");
        #1 strap = 3'b010;
        m.start_cond();
        send(8'ha4, 1'b1);
        send(8'h03, 1'b1);
        send(8'hfe, 1'b1);
        for (int i = 0; i < 4; i++)
            send(8'(8'h11 * (i + 1)), 1'b1);
        m.stop_cond();
        for (int i = 0; i < 4; i++) begin
            lo = 7'h7e + 7'(i);
            pop_word({9'h007, lo, 8'(8'h11 * (i + 1))});
        end
        wait_idle();
        done("page wrap");
        #1 wp = 1'b1;
        m.start_cond();
        send(8'ha4, 1'b1);
        send(8'h00, 1'b1);
        send(8'h10, 1'b1);
        send(8'h77, 1'b1);
        m.stop_cond();
        repeat (10) @(posedge clk);
        cmp1(wq.size() == 0 && commits == 2, 1'b1);
        cmp1(busy, 1'b0);
        #1 wp = 1'b0;
        done("write protect");
        #1 word_ready = 1'b0;
        m.start_cond();
        send(8'ha4, 1'b1);
        send(8'h00, 1'b1);
        send(8'h20, 1'b1);
        send(8'ha1, 1'b1);
        send(8'hb2, 1'b1);
        send(8'hc3, 1'b0);
        m.stop_cond();
        repeat (5) @(posedge clk);
        cmp1(wq.size() == 0 && word_valid, 1'b1);
        #1 word_ready = 1'b1;
        repeat (5) @(posedge clk);
        pop_word(24'h0020a1);
        pop_word(24'h0021b2);
        cmp1(wq.size() == 0, 1'b1);
        wait_idle();
        done("buffer full");
        m.start_cond();
        m.bit_out(1'b1);
        m.bit_out(1'b0);
        m.bit_out(1'b1);
        m.start_cond();
        repeat (9) m.bit_out(1'b1);
        m.start_cond();
        m.stop_cond();
        m.start_cond();
        send(8'ha4, 1'b1);
        m.stop_cond();
        wait_idle();
        done("protocol recovery");
        summarize();
    end
endmodule // test_two_wire_eeprom_write_port

bind eewp_port eewp_port_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
    .CLK(CLK), .RESET_N(RESET_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .WRITE_PROTECT(WRITE_PROTECT), .WORD_VALID(WORD_VALID),
    .WORD_ADDR(WORD_ADDR), .WORD_DATA(WORD_DATA), .WORD_READY(WORD_READY),
    .WRITE_COMMIT(WRITE_COMMIT), .WRITE_BUSY(WRITE_BUSY), .STANDBY(STANDBY));
